// ==== opb_defs.svh ====
`ifndef OPB_DEFS_SVH
`define OPB_DEFS_SVH
// register byte offsets
`define OPB_CTRL_OFS    6'h00
`define OPB_LOAD_OFS    6'h04
`define OPB_MIX_OFS     6'h08
`define OPB_PALPTR_OFS  6'h0c
`define OPB_TOPPTR_OFS  6'h10
`define OPB_BOTPTR_OFS  6'h14
`define OPB_PIXCNT_OFS  6'h18
`define OPB_STATUS_OFS  6'h1c
// control field positions
`define OPB_CTRL_START  0
`define OPB_CTRL_NEWPAL 1
`define OPB_CTRL_MERGE  2
`define OPB_CTRL_MODE_L 4
// lookup table entry layout
`define OPB_RED_MSB     31
`define OPB_RED_LSB     24
`define OPB_GRN_MSB     23
`define OPB_GRN_LSB     16
`define OPB_BLU_MSB     15
`define OPB_BLU_LSB     8
`define OPB_MIX_MSB     7
// mix factor limit, gain multiply bit, word step and reset value
`define OPB_MIX_FULL    8'h80
`define OPB_GAIN_MULT   8
`define OPB_WORD_BYTES  32'h4
`define OPB_RESET_WORD  32'h0
`endif

// ==== opb_mem_model.sv ====
`timescale 1ns/100ps
module opb_mem_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // sdram side
   input  wire logic        memRead,
   input  wire logic [31:0] memAddress,
   output logic             memWaitrequest,
   output logic      [31:0] memReaddata,
   // compositor side
   input  wire logic        pixValid,
   output logic             pixReady,
   input  wire logic [7:0]  pixRed,
   input  wire logic [7:0]  pixGreen,
   input  wire logic [7:0]  pixBlue,
   input  wire logic [7:0]  pixMix,
   input  wire logic        pixTopField
);
   logic [31:0] mem [0:4095];
   logic [32:0] pixQ [$];
   logic [2:0]  cnt;
   // free-running pattern so both ends stall now and then
   always_ff @(posedge clk) begin
      if (reset) cnt <= 3'h0;
      else cnt <= cnt + 3'h1;
   end
   assign memWaitrequest = (cnt[1:0] == 2'h1);
   assign pixReady       = (cnt != 3'h5);
   // data only at a grant; otherwise a changing pattern, not stale words
   assign memReaddata = (memRead && !memWaitrequest) ? mem[memAddress[13:2]] : {8{cnt, 1'b0}};
   // compositor takes a pixel when both sides agree; bench pops, so not always_ff
   always @(posedge clk) begin
      if (!reset && pixValid && pixReady) begin
         pixQ.push_back({pixTopField, pixRed, pixGreen, pixBlue, pixMix});
      end
   end
endmodule : opb_mem_model

// ==== opb_palette_blend.sv ====
`timescale 1ns/100ps
`include "opb_defs.svh"
// How it works
// R1: table entry is 32 bits: red top byte, green, blue, mix factor lowest.
// R2: stored mix factor above 80h counts as 80h.
// R3: palette words are copied into the table before the region's pixels show.
// R4: copy load count plus one entries, so zero copies one colour.
// R5: never more than 256 colours written per load.
// R6: start index places the first colour only; lookups use pixel value directly.
// R7: later regions keep the table unless the new palette flag is set.
// R8: palette pointer is a byte address; colours read from successive words.
// R9: 8-bit pixels, left to right, each indexes the table for its colour.
// R10: first bitmap line is top field, last is bottom field.
// R11: software stores each field block word aligned, both same pixel count.
// R12: each field fetched from own pointer; merged line layout also accepted.
// R13: two-bit mode selects pixel, region, proportional or no mixing.
// R14: pixel mode uses the table mix factor only.
// R15: region mode uses the region weight for every pixel.
// R16: proportional mode multiplies by gain or divides by gain over 128.
// R17: no-mixing mode gives full overlay, table factor ignored.
// R18: region weight above 80h counts as 80h.
// R19: four pixels per word, earliest in bits 7..0.
// R20: proportional result saturates at 128.
module opb_palette_blend
   import opb_pkg::*;
#(
   parameter int PIX_CNT_W = 22
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // register slave
   input  wire logic [5:0]  avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWritedata,
   output logic      [31:0] avsReaddata,
   output logic             avsWaitrequest,
   // sdram read master
   output logic             memRead,
   output logic      [31:0] memAddress,
   input  wire logic        memWaitrequest,
   input  wire logic [31:0] memReaddata,
   // compositor stream
   output logic             pixValid,
   input  wire logic        pixReady,
   output logic      [7:0]  pixRed,
   output logic      [7:0]  pixGreen,
   output logic      [7:0]  pixBlue,
   output logic      [7:0]  pixMix,
   output logic             pixTopField
);
   // software-visible settings
   logic                 newPaletteFlag, mergedLayout, avsAck, startReq, firstDone;
   logic [1:0]           blendModeSelect;
   logic [7:0]           paletteLoadCount, paletteLoadStartIndex, regionMixWeight;
   logic [8:0]           mixGain;
   logic [31:0]          palettePtr, topPtr, bottomPtr;
   logic [PIX_CNT_W-1:0] pixelCount;
   // working state
   opb_state_e           state;
   logic [31:0]          clut [256];
   logic [8:0]           palWrites;
   logic [7:0]           clutIdx;
   logic [31:0]          bmWord;
   logic [1:0]           byteSel;
   logic [PIX_CNT_W-1:0] pixLeft;
   logic                 inBottom;
   logic [1:0]           curMode;
   logic [7:0]           curWeight;
   logic [8:0]           curGain;
   logic                 memDone, emitStep, lastPix;
   logic [7:0]           curPix;
   logic [31:0]          entry;

   // clamp any factor to full overlay
   function automatic logic [7:0] clampMix(input logic [15:0] v);
      clampMix = (v > 16'(`OPB_MIX_FULL)) ? `OPB_MIX_FULL : v[7:0];
   endfunction : clampMix

   // derive the factor handed to the compositor
   function automatic logic [7:0] blendFactor(input logic [1:0] mode, input logic [7:0] raw,
                                               input logic [7:0] wt, input logic [8:0] gain);
      logic [7:0]  alpha;
      logic [15:0] scaled;
      alpha  = clampMix({8'h00, raw});                                 // R2
      scaled = 16'h0000;
      case (mode)
         BLEND_PIXEL:  blendFactor = alpha;                            // R14
         BLEND_REGION: blendFactor = clampMix({8'h00, wt});            // R15 R18
         BLEND_PROP: begin
            if (gain[`OPB_GAIN_MULT]) begin
               scaled = alpha * gain[7:0];                             // R16
            end else if (gain[7:0] == 8'h00) begin
               scaled = 16'(`OPB_MIX_FULL);                            // divide by zero saturates
            end else begin
               scaled = {1'b0, alpha, 7'h00} / {8'h00, gain[7:0]};     // R16
            end
            blendFactor = clampMix(scaled);                            // R20
         end
         BLEND_NONE:   blendFactor = `OPB_MIX_FULL;                    // R17
         default:      blendFactor = `OPB_MIX_FULL;
      endcase
   endfunction : blendFactor

   // bus answers one cycle after the request is seen
   assign avsWaitrequest = (avsRead | avsWrite) & ~avsAck;

   always_ff @(posedge clk) begin
      if (reset) begin
         avsAck <= 1'b0;
      end else begin
         avsAck <= (avsRead | avsWrite) & ~avsAck;
      end
   end

   // register writes; start is a self-clearing strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         startReq              <= 1'b0;
         newPaletteFlag        <= 1'b0;
         mergedLayout          <= 1'b0;
         blendModeSelect       <= 2'b00;
         paletteLoadCount      <= 8'h00;
         paletteLoadStartIndex <= 8'h00;
         regionMixWeight       <= 8'h00;
         mixGain               <= 9'h000;
         palettePtr            <= `OPB_RESET_WORD;
         topPtr                <= `OPB_RESET_WORD;
         bottomPtr             <= `OPB_RESET_WORD;
         pixelCount            <= '0;
      end else begin
         startReq <= 1'b0;
         if (avsWrite && avsAck) begin
            case (avsAddress)
               `OPB_CTRL_OFS: begin
                  startReq        <= avsWritedata[`OPB_CTRL_START] && (state == ST_IDLE);
                  newPaletteFlag  <= avsWritedata[`OPB_CTRL_NEWPAL];
                  mergedLayout    <= avsWritedata[`OPB_CTRL_MERGE];
                  blendModeSelect <= avsWritedata[`OPB_CTRL_MODE_L+:2];      // R13
               end
               `OPB_LOAD_OFS: begin
                  paletteLoadCount      <= avsWritedata[7:0];
                  paletteLoadStartIndex <= avsWritedata[15:8];
               end
               `OPB_MIX_OFS: begin
                  regionMixWeight <= avsWritedata[7:0];
                  mixGain         <= avsWritedata[16:8];
               end
               `OPB_PALPTR_OFS: palettePtr <= avsWritedata;
               `OPB_TOPPTR_OFS: topPtr     <= avsWritedata;
               `OPB_BOTPTR_OFS: bottomPtr  <= avsWritedata;
               `OPB_PIXCNT_OFS: pixelCount <= avsWritedata[PIX_CNT_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // read data; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (reset) begin
         avsReaddata <= `OPB_RESET_WORD;
      end else if (avsRead && !avsAck) begin
         case (avsAddress)
            `OPB_CTRL_OFS:   avsReaddata <= {26'h0, blendModeSelect, 1'b0, mergedLayout,
                                             newPaletteFlag, 1'b0};
            `OPB_LOAD_OFS:   avsReaddata <= {16'h0, paletteLoadStartIndex, paletteLoadCount};
            `OPB_MIX_OFS:    avsReaddata <= {15'h0, mixGain, regionMixWeight};
            `OPB_PALPTR_OFS: avsReaddata <= palettePtr;
            `OPB_TOPPTR_OFS: avsReaddata <= topPtr;
            `OPB_BOTPTR_OFS: avsReaddata <= bottomPtr;
            `OPB_PIXCNT_OFS: avsReaddata <= 32'(pixelCount);
            `OPB_STATUS_OFS: avsReaddata <= {15'h0, palWrites, 3'h0, inBottom, firstDone,
                                             state};
            default:         avsReaddata <= `OPB_RESET_WORD;
         endcase
      end
   end

   assign memDone  = memRead & ~memWaitrequest;
   assign curPix   = bmWord[{byteSel, 3'b000}+:8];                    // R19
   assign entry    = clut[curPix];                                    // R6 R9
   assign emitStep = (state == ST_EMIT) && (!pixValid || pixReady);
   assign lastPix  = (pixLeft == PIX_CNT_W'(1));

   // sequencer: palette copy, then word fetch and pixel emit per field
   always_ff @(posedge clk) begin
      if (reset) begin
         state      <= ST_IDLE;
         memRead    <= 1'b0;
         memAddress <= `OPB_RESET_WORD;
         palWrites  <= 9'h000;
         clutIdx    <= 8'h00;
         bmWord     <= `OPB_RESET_WORD;
         byteSel    <= 2'b00;
         pixLeft    <= '0;
         inBottom   <= 1'b0;
         firstDone  <= 1'b0;
         curMode    <= 2'b00;
         curWeight  <= 8'h00;
         curGain    <= 9'h000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (startReq) begin
                  curMode   <= blendModeSelect;
                  curWeight <= regionMixWeight;
                  curGain   <= mixGain;
                  inBottom  <= 1'b0;
                  pixLeft   <= pixelCount;
                  palWrites <= 9'h000;
                  clutIdx   <= paletteLoadStartIndex;                   // R6
                  memRead   <= 1'b1;
                  if (newPaletteFlag || !firstDone) begin               // R7
                     state      <= ST_PAL;                              // R3
                     memAddress <= palettePtr;                          // R8
                  end else begin
                     state      <= ST_FETCH;
                     memAddress <= topPtr;                              // R12
                  end
               end
            end
            ST_PAL: begin
               if (memDone) begin
                  clutIdx    <= clutIdx + 8'h01;
                  palWrites  <= palWrites + 9'h001;
                  memAddress <= memAddress + `OPB_WORD_BYTES;           // R8
                  if (palWrites == {1'b0, paletteLoadCount}) begin      // R4 R5
                     state      <= ST_FETCH;
                     memAddress <= topPtr;
                  end
               end
            end
            ST_FETCH: begin
               if (pixLeft == '0) begin
                  memRead <= 1'b0;
                  if (inBottom || pixelCount == '0) begin
                     state     <= ST_IDLE;
                     firstDone <= 1'b1;
                  end else begin
                     // second field: own pointer, or straight after top when merged
                     inBottom <= 1'b1;                                  // R10
                     pixLeft  <= pixelCount;
                     memRead  <= 1'b1;
                     if (!mergedLayout) begin
                        memAddress <= bottomPtr;                        // R12
                     end
                  end
               end else if (memDone) begin
                  memRead    <= 1'b0;
                  bmWord     <= memReaddata;
                  byteSel    <= 2'b00;
                  memAddress <= memAddress + `OPB_WORD_BYTES;
                  state      <= ST_EMIT;
               end else begin
                  memRead <= 1'b1;
               end
            end
            ST_EMIT: begin
               if (emitStep) begin
                  byteSel <= byteSel + 2'b01;                           // R9
                  pixLeft <= pixLeft - PIX_CNT_W'(1);
                  if (byteSel == 2'b11 || lastPix) begin
                     state   <= ST_FETCH;
                     memRead <= !lastPix;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // table write port; index wraps so at most 256 distinct entries
   always_ff @(posedge clk) begin
      if (state == ST_PAL && memDone) begin
         clut[clutIdx] <= memReaddata;                                  // R1 R3
      end
   end

   // output pixel register, stalls on compositor back-pressure
   always_ff @(posedge clk) begin
      if (reset) begin
         pixValid    <= 1'b0;
         pixRed      <= 8'h00;
         pixGreen    <= 8'h00;
         pixBlue     <= 8'h00;
         pixMix      <= 8'h00;
         pixTopField <= 1'b1;
      end else if (emitStep) begin
         pixValid    <= 1'b1;
         pixRed      <= entry[`OPB_RED_MSB:`OPB_RED_LSB];               // R1
         pixGreen    <= entry[`OPB_GRN_MSB:`OPB_GRN_LSB];
         pixBlue     <= entry[`OPB_BLU_MSB:`OPB_BLU_LSB];
         pixMix      <= blendFactor(curMode, entry[`OPB_MIX_MSB:0], curWeight, curGain); // R13
         pixTopField <= !inBottom;                                      // R10
      end else if (pixReady) begin
         pixValid <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   mix_never_over_a: assert property (pixValid |-> pixMix <= `OPB_MIX_FULL) // R2
      else $error("mix factor above full overlay");
   nomix_full_a: assert property ($rose(pixValid) && curMode == BLEND_NONE
                                  |-> pixMix == `OPB_MIX_FULL)             // R17
      else $error("no-mixing mode not full overlay");
   region_weight_a: assert property (emitStep && curMode == BLEND_REGION
                                     |=> pixMix == ((curWeight > 8'h80) ? 8'h80 : curWeight)) // R15
      else $error("region weight not applied");
   pal_count_a: assert property (state == ST_PAL ##1 state == ST_FETCH
                                 |-> palWrites == {1'b0, paletteLoadCount} + 9'h001) // R4
      else $error("wrong number of palette entries copied");
   pal_start_idx_a: assert property ($rose(state == ST_PAL)
                                     |-> clutIdx == paletteLoadStartIndex) // R6
      else $error("first colour at wrong index");
   pal_contig_a: assert property (state == ST_PAL && memDone && state == ST_PAL
                                  ##1 state == ST_PAL
                                  |-> memAddress == $past(memAddress) + `OPB_WORD_BYTES) // R8
      else $error("palette words not contiguous");
   keep_palette_a: assert property (state == ST_IDLE && startReq && firstDone &&
                                    !newPaletteFlag |=> state == ST_FETCH) // R7
      else $error("palette reloaded without request");
   top_first_a: assert property ($rose(state == ST_FETCH) && $past(state) != ST_EMIT
                                 |-> !inBottom) // R10
      else $error("region did not start in top field");
   bus_answer_a: assert property ((avsRead || avsWrite) && !avsAck |=> !avsWaitrequest)
      else $error("bus answer late");
endmodule : opb_palette_blend

// ==== opb_palette_blend_tb.sv ====
`timescale 1ns/100ps
`include "opb_defs.svh"
module opb_palette_blend_tb
   import opb_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [5:0]  avsAddress = 6'h0;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h0;
   logic [31:0] avsReaddata, memAddress, memReaddata, rdat;
   logic        avsWaitrequest, memRead, memWaitrequest, pixValid, pixReady, pixTopField;
   logic [7:0]  pixRed, pixGreen, pixBlue, pixMix;
   logic [31:0] clut [0:255];
   int          fail_count = 0;
   int          check_count = 0;
   // 250 MHz
   always #2 clk = ~clk;
   opb_palette_blend u_opb_palette_blend (.clk(clk), .reset(reset), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
      .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .memRead(memRead),
      .memAddress(memAddress), .memWaitrequest(memWaitrequest), .memReaddata(memReaddata),
      .pixValid(pixValid), .pixReady(pixReady), .pixRed(pixRed), .pixGreen(pixGreen),
      .pixBlue(pixBlue), .pixMix(pixMix), .pixTopField(pixTopField));
   opb_mem_model u_opb_mem_model (.clk(clk), .reset(reset), .memRead(memRead),
      .memAddress(memAddress), .memWaitrequest(memWaitrequest), .memReaddata(memReaddata),
      .pixValid(pixValid), .pixReady(pixReady), .pixRed(pixRed), .pixGreen(pixGreen),
      .pixBlue(pixBlue), .pixMix(pixMix), .pixTopField(pixTopField));
   task automatic give_verdict();
      if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic timeout();
      fail_count++;
      give_verdict();
   endtask : timeout
   task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // one bus cycle; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= !wr;
      avsWritedata <= d;
      n = 0;
      // values seen here are those sampled at this rising edge
      do begin
         @(posedge clk);
         n++;
      end while (avsWaitrequest !== 1'b0 && n < 20);
      q = avsReaddata;
      if (n >= 20) timeout();
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask : bus
   // palette word pattern; alpha straddles the clamp point
   function automatic logic [31:0] palw(input int w);
      logic [7:0] b;
      b = w[7:0];
      return {b, ~b, b ^ 8'h3c, b + 8'h70};
   endfunction : palw
   function automatic logic [7:0] mixf(input opb_blend_e m, input logic [7:0] al,
                                       input logic [7:0] wt, input logic [8:0] g);
      int a;
      int r;
      a = (al > 8'h80) ? 128 : int'(al);
      case (m)
         BLEND_PIXEL:  r = a;
         BLEND_REGION: r = (wt > 8'h80) ? 128 : int'(wt);
         BLEND_PROP:   r = g[8] ? a * g[7:0] : ((g[7:0] == 8'h0) ? 128 : a * 128 / g[7:0]);
         default:      r = 128;
      endcase
      return (r > 128) ? 8'h80 : r[7:0];
   endfunction : mixf
   // program one region, run it, judge every pixel of both fields
   task automatic run_region(input opb_blend_e m, input logic np, input logic mg,
      input logic [7:0] cnt, input logic [7:0] st, input logic [7:0] wt,
      input logic [8:0] g, input int n, input int pal);
      logic [7:0] pv [$];
      int k;
      int f;
      int tp;
      int bp;
      tp = 32'h2000;
      bp = mg ? tp + 4 * ((n + 3) / 4) : 32'h2800;
      for (f = 0; f < 2; f++) begin
         for (k = 0; k < n; k++) begin
            pv.push_back(8'(k * 37 + f * 64 + pal / 4));
            u_opb_mem_model.mem[((f ? bp : tp) >> 2) + k / 4][8 * (k % 4) +: 8] = pv[$];
         end
      end
      if (np) for (k = 0; k <= cnt; k++) clut[8'(st + k)] = palw(pal / 4 + k);
      bus(1'b1, `OPB_PALPTR_OFS, pal, rdat);
      bus(1'b1, `OPB_LOAD_OFS, {16'h0, st, cnt}, rdat);
      bus(1'b1, `OPB_MIX_OFS, {15'h0, g, wt}, rdat);
      bus(1'b1, `OPB_TOPPTR_OFS, tp, rdat);
      bus(1'b1, `OPB_BOTPTR_OFS, bp, rdat);
      bus(1'b1, `OPB_PIXCNT_OFS, n, rdat);
      bus(1'b1, `OPB_CTRL_OFS, {26'h0, m, 1'b0, mg, np, 1'b1}, rdat);
      k = 0;
      do begin
         bus(1'b0, `OPB_STATUS_OFS, 32'h0, rdat);
         k++;
      end while ((u_opb_mem_model.pixQ.size() < 2 * n || rdat[2:0] !== 3'h0) && k < 600);
      if (k >= 600) timeout();
      for (k = 0; k < 2 * n; k++) begin
         chk("pixel", {k < n, clut[pv[k]][31:8], mixf(m, clut[pv[k]][7:0], wt, g)},
             u_opb_mem_model.pixQ.pop_front());
      end
   endtask : run_region
   task automatic t_reset();
      chk("idle outputs", 33'h2, {pixValid, memRead, pixTopField, avsWaitrequest});
      bus(1'b0, `OPB_STATUS_OFS, 32'h0, rdat);
      chk("status", 33'h0, rdat);
      bus(1'b1, 6'h24, 32'hffffffff, rdat);
      bus(1'b0, 6'h24, 32'h0, rdat);
      chk("unmapped", 33'h0, rdat);
   endtask : t_reset
   task automatic t_full_load();
      run_region(BLEND_PIXEL, 1'b1, 1'b0, 8'hff, 8'h01, 8'h00, 9'h0, 6, 32'h400);
      chk("copied", 33'd256, 33'(rdat[16:8]));
   endtask : t_full_load
   task automatic t_one_colour();
      run_region(BLEND_REGION, 1'b1, 1'b0, 8'h00, 8'h05, 8'h90, 9'h0, 3, 32'h814);
      chk("copied", 33'd1, 33'(rdat[16:8]));
   endtask : t_one_colour
   task automatic t_keep_merged();
      run_region(BLEND_PROP, 1'b0, 1'b1, 8'h10, 8'h00, 8'h00, 9'h103, 4, 32'hc14);
   endtask : t_keep_merged
   task automatic t_divide();
      run_region(BLEND_PROP, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 9'h040, 3, 32'h0);
   endtask : t_divide
   task automatic t_no_mix();
      run_region(BLEND_NONE, 1'b0, 1'b0, 8'h00, 8'h00, 8'h10, 9'h0, 2, 32'h1c);
   endtask : t_no_mix
   // main sequence
   initial begin
      for (int w = 0; w < 1024; w++) u_opb_mem_model.mem[w] = palw(w);
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_full_load();
      t_one_colour();
      t_keep_merged();
      t_divide();
      t_no_mix();
      give_verdict();
   end
endmodule : opb_palette_blend_tb

// ==== opb_pkg.sv ====
package opb_pkg;
   // blend mode encodings
   typedef enum logic [1:0] {
      BLEND_PIXEL  = 2'b00,
      BLEND_REGION = 2'b01,
      BLEND_PROP   = 2'b10,
      BLEND_NONE   = 2'b11
   } opb_blend_e;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_PAL   = 3'b001,
      ST_FETCH = 3'b010,
      ST_EMIT  = 3'b011
   } opb_state_e;
endpackage : opb_pkg
